/* tb/mcg_card_checker.sv */
`timescale 1ns/100ps
module mcg_card_checker
  import mcg_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Card lines
  input wire logic        cmd_out,
  input wire logic        cmd_oe,
  input wire logic        dat_out,
  input wire logic        dat_oe,
  input wire logic [11:0] blk_len,
  input wire mcg_status_t status
);
  logic [5:0]  rcnt_r;
  logic [6:0]  rcrc_r;
  logic [14:0] dcnt_r;
  logic [15:0] dcrc_r;
  wire  [14:0] nbits = {blk_len, 3'b000};

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Shadow remainders, rebuilt from the wire and cleared whenever the line is released
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rcnt_r <= '0;
      rcrc_r <= '0;
    end
    else
    begin
      rcnt_r <= cmd_oe ? rcnt_r + 6'd1 : 6'd0;
      rcrc_r <= !cmd_oe ? 7'h00 : {rcrc_r[5:0], 1'b0} ^ ({7{(rcrc_r[6] ^ cmd_out) && rcnt_r < 6'd40}} & 7'h09);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dcnt_r <= '0;
      dcrc_r <= '0;
    end
    else
    begin
      dcnt_r <= dat_oe ? dcnt_r + 15'd1 : 15'd0;
      dcrc_r <= !dat_oe ? 16'h0000 :
                {dcrc_r[14:0], 1'b0} ^ ({16{(dcrc_r[15] ^ dat_out) && dcnt_r != 0 && dcnt_r <= nbits}} & 16'h1021);
    end
  end

  ////////////////////////////////////////
  rst_vals_a: assert property ($rose(resetn) |-> status == '0 && !cmd_oe && !dat_oe)
    else $error("outputs not at reset values");
  rsp_start_a: assert property ($rose(cmd_oe) |-> !cmd_out ##1 !cmd_out)
    else $error("response start bits wrong");
  rsp_crc_a: assert property (cmd_oe && rcnt_r >= 6'd40 && rcnt_r <= 6'd46 |-> cmd_out == rcrc_r[6])
    else $error("response check bits wrong");
  rsp_len_a: assert property ($fell(cmd_oe) |-> $past(rcnt_r) == 6'd47 && $past(cmd_out))
    else $error("response length or end bit wrong");
  dat_start_a: assert property ($rose(dat_oe) |-> !dat_out)
    else $error("data start bit wrong");
  dat_crc_a: assert property (dat_oe && dcnt_r > nbits && dcnt_r <= nbits + 15'd16 |-> dat_out == dcrc_r[15])
    else $error("data check bits wrong");
  dat_len_a: assert property ($fell(dat_oe) |-> $past(dcnt_r) == nbits + 15'd17 && $past(dat_out))
    else $error("data block length or end bit wrong");
  bus_excl_a: assert property (dat_oe |-> !cmd_oe)
    else $error("data sent during response");

  cover property ($fell(cmd_oe));
  cover property ($fell(dat_oe));
  cover property (status.crc_err);
endmodule : mcg_card_checker

bind mcg_card mcg_card_checker i_chk (.clk, .resetn, .cmd_out, .cmd_oe, .dat_out, .dat_oe, .blk_len, .status);

/* tb/mcg_host_model.sv */
`timescale 1ns/100ps
module mcg_host_model
(
  // Clock
  input wire logic clk,
  // Card lines
  input wire logic cmd_out,
  input wire logic cmd_oe,
  input wire logic dat_out,
  input wire logic dat_oe,
  // Command drive
  output logic     cmd_in
);
  logic [47:0] rsp;
  logic        dq[$];

  initial cmd_in = 1'b1;

  function automatic logic [6:0] crc7(input logic [39:0] m);
    logic [6:0] c;
    c = '0;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ({7{c[6] ^ m[i]}} & 7'h09);
    return c;
  endfunction : crc7

  // A bad frame inverts its check bits so the card must reject it
  task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
    logic [47:0] f;
    f = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {7{bad}}, 1'b1};
    for (int i = 47; i >= 0; i--)
    begin
      @(negedge clk);
      cmd_in = f[i];
    end
    @(negedge clk);
  endtask : send

  task automatic get_rsp(output logic ok);
    ok = 1'b0;
    for (int w = 0; w < 40 && !ok; w++)
    begin
      @(negedge clk);
      ok = cmd_oe;
    end
    for (int i = 47; i >= 0 && ok; i--)
    begin
      if (i < 47)
        @(negedge clk);
      rsp[i] = cmd_out;
    end
  endtask : get_rsp

  task automatic get_dat(input int n, input int wmax, output logic ok);
    ok = 1'b0;
    dq.delete();
    for (int w = 0; w < wmax && !ok; w++)
    begin
      @(negedge clk);
      ok = dat_oe;
    end
    for (int i = 0; i < n && ok; i++)
    begin
      if (i > 0)
        @(negedge clk);
      dq.push_back(dat_out);
    end
  endtask : get_dat
endmodule : mcg_host_model

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import mcg_pkg::*;
  // Init and ident delays cut to 64 cycles to keep the run short
  localparam int T_INIT = 64;
  logic        clk;
  logic        resetn;
  logic        vdd_ok;
  logic        mem_valid;
  logic [7:0]  mem_data;
  logic [11:0] blk_len;
  logic        cmd_in;
  logic        cmd_out;
  logic        cmd_oe;
  logic        dat_out;
  logic        dat_oe;
  logic        mem_req;
  logic        mem_ready;
  logic [31:0] mem_addr;
  mcg_status_t status;
  int          num_errors;
  int          comparisons;
  int          cyc;

  mcg_card i_dut (.clk, .resetn, .vdd_ok, .cmd_in, .cmd_out, .cmd_oe, .dat_out, .dat_oe, .mem_req, .mem_addr,
                  .mem_valid, .mem_data, .mem_ready, .blk_len, .status);
  mcg_host_model i_host (.clk, .cmd_out, .cmd_oe, .dat_out, .dat_oe, .cmd_in);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic [4:0] st);
    logic ok;
    i_host.send(idx, arg, 1'b0);
    i_host.get_rsp(ok);
    chk("rsp seen", 1, ok);
    chk("rsp index", idx, i_host.rsp[45:40]);
    chk("rsp crc", i_host.crc7(i_host.rsp[47:8]), i_host.rsp[7:1]);
    if (st != 5'h1f)
      chk("rsp state", st, i_host.rsp[15:11]);
  endtask : cmd

  task automatic t_early;
    logic ok;
    chk("reset status", 0, status);
    i_host.send(6'h11, 0, 1'b0);
    i_host.get_rsp(ok);
    chk("early ignored", 0, ok);
  endtask : t_early

  task automatic t_init;
    logic ok;
    i_host.send(6'h01, 0, 1'b1);
    i_host.get_rsp(ok);
    chk("bad crc answered", 1, ok);
    chk("crc flag", 1, i_host.rsp[17]);
    chk("not executed", 0, i_host.rsp[15:11]);
    cmd(6'h01, 0, 5'd1);
    chk("flag cleared", 0, i_host.rsp[17]);
    repeat (T_INIT) @(negedge clk);
    cmd(6'h02, 0, 5'd2);
    cmd(6'h03, 32'h0001_0000, 5'd3);
  endtask : t_init

  // Full 2048-byte block: the FIFO fills and stalls while bits drain slowly
  task automatic t_read;
    logic        ok;
    logic        e;
    logic [7:0]  bt;
    logic [15:0] c;
    cmd(6'h11, 32'h0000_0010, 5'd4);
    i_host.get_dat(16402, 600, ok);
    chk("data seen", 1, ok);
    c = 16'h0000;
    for (int k = 0; k < 16384 && ok; k++)
    begin
      bt = 8'(32'h0000_0010 + k / 8) ^ 8'hA5;
      e = bt[7 - k % 8];
      c = {c[14:0], 1'b0} ^ ({16{c[15] ^ e}} & 16'h1021);
      chk("data bit", e, i_host.dq[k + 1]);
    end
    for (int k = 0; k < 16 && ok; k++)
      chk("data crc", c[15 - k], i_host.dq[16385 + k]);
    if (ok)
      chk("data frame", 2'b01, {i_host.dq[0], i_host.dq[16401]});
    vdd_ok = 1'b0;
    i_host.send(6'h11, 32'h0000_0020, 1'b0);
    i_host.get_rsp(ok);
    chk("gated answered", 1, ok);
    chk("gated state", 3, i_host.rsp[15:11]);
    i_host.get_dat(34, 300, ok);
    chk("read gated", 0, ok);
    vdd_ok = 1'b1;
  endtask : t_read

  task automatic t_goidle;
    logic ok;
    cmd(6'h03, 0, 5'd3);
    chk("illegal flag", 1, i_host.rsp[16]);
    chk("illegal cleared", 0, status.illegal);
    i_host.send(6'h00, 0, 1'b0);
    i_host.get_rsp(ok);
    chk("go idle silent", 0, ok);
    chk("go idle status", 0, status);
    i_host.send(6'h11, 0, 1'b0);
    i_host.get_rsp(ok);
    chk("read after reset", 0, ok);
  endtask : t_goidle

  ////////////////////////////////////////
  // Memory source stalls one cycle in four
  always @(negedge clk)
  begin
    cyc <= cyc + 1;
    mem_valid <= (cyc % 4) != 0;
    mem_data <= mem_addr[7:0] ^ 8'hA5;
    if (cyc == 60000)
    begin
      num_errors++;
      tally_and_finish;
    end
  end

  initial
  begin
    resetn = 1'b0;
    vdd_ok = 1'b1;
    mem_valid = 1'b0;
    mem_data = 8'h00;
    blk_len = 12'h800;
    num_errors = 0;
    comparisons = 0;
    cyc = 0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (T_INIT) @(negedge clk);
    t_early;
    t_init;
    t_read;
    t_goidle;
    tally_and_finish;
  end
endmodule : testbench

/* verilog/mcg_card.sv */
`timescale 1ns/100ps
`include "mcg_cfg.svh"
// Contract
// RULE1 - Command and response frames use 7-bit CRC, polynomial x^7+x^3+1.
// RULE2 - Every received command's CRC is checked before acting on it.
// RULE3 - Every response carries a freshly computed 7-bit CRC.
// RULE4 - Failed-CRC command is not executed, yet a response is still sent.
// RULE5 - Each read block is followed by 16-bit CRC, x^16+x^12+x^5+1.
// RULE6 - Data CRC supports payloads up to 2048 bytes.
// RULE7 - Host reacts to CRC failures, normally by reissuing the command.
// RULE8 - Power-on detect puts all logic in a defined state, no external reset; the code resets from the external resetn input instead.
// RULE9 - Go-idle command returns the card to its power-on state.
// RULE10 - Parser works after power-on; memory access waits for supply good.
// RULE11 - Host waits 1 ms after operating-condition command before identify; the testbench waits 64 cycles (T_INIT) instead.
// RULE12 - Host allows 1 ms or 64 cycles initialization delay.
// RULE13 - Identification delay applies at power-up and hot insertion.
// RULE14 - Commands ignored until op-cond, all-identify and address assignment.
// RULE15 - No memory access during idle, ready, ident or inactive states.
// RULE16 - CRC failure sets communication-CRC flag reported in next status.
// RULE17 - Error flags clear once the host has read them.
// RULE18 - CRCs run serially MSB first, cleared at each frame start bit.
// RULE19 - Data CRC sent MSB first right after the last payload bit.
module mcg_card
  import mcg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Supply monitor
  input  wire logic        vdd_ok,
  // Command line
  input  wire logic        cmd_in,
  output logic             cmd_out,
  output logic             cmd_oe,
  // Data line
  output logic             dat_out,
  output logic             dat_oe,
  // Memory byte source
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  input  wire logic        mem_valid,
  input  wire logic [7:0]  mem_data,
  output logic             mem_ready,
  // Block length
  input  wire logic [11:0] blk_len,
  // State view
  output mcg_status_t      status
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
    logic fb;
    fb = c[6] ^ b;
    return {c[5:0], 1'b0} ^ (fb ? `MCG_CRC7_POLY : 7'h00);
  endfunction : crc7_step
  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    return {c[14:0], 1'b0} ^ (fb ? `MCG_CRC16_POLY : 16'h0000);
  endfunction : crc16_step

  ////////////////////////////////////////////////////////////////////////
  // Power-on: a short internal stretch after reset release
  logic [3:0]  por_cnt_r;
  logic        por_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      por_cnt_r <= 4'h0;
      por_r     <= 1'b1;
    end
    else if (por_cnt_r != `MCG_POR_CYCLES)
      por_cnt_r <= por_cnt_r + 4'h1;
    else
      por_r <= 1'b0; // RULE8
  end

  ////////////////////////////////////////////////////////////////////////
  // Command receiver
  logic        rx_busy_r;
  logic [5:0]  rx_cnt_r;
  logic [39:0] rx_sh_r;
  logic [6:0]  rx_crc_r;
  logic [6:0]  rx_chk_r;
  logic        rx_done_r;
  logic        tx_busy_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_busy_r <= 1'b0;
      rx_cnt_r  <= 6'h00;
      rx_sh_r   <= '0;
      rx_crc_r  <= 7'h00;
      rx_chk_r  <= 7'h00;
      rx_done_r <= 1'b0;
    end
    else
    begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r)
      begin
        if (!cmd_in && !tx_busy_r && !por_r)
        begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= 6'h01;
          rx_sh_r   <= {39'h0, cmd_in};
          rx_crc_r  <= crc7_step(7'h00, cmd_in); // RULE18
        end
      end
      else if (rx_cnt_r < `MCG_CMD_BITS)
      begin
        rx_cnt_r <= rx_cnt_r + 6'h01;
        rx_sh_r  <= {rx_sh_r[38:0], cmd_in};
        rx_crc_r <= crc7_step(rx_crc_r, cmd_in); // RULE1
      end
      else if (rx_cnt_r < `MCG_CMD_BITS + 6'd7)
      begin
        rx_cnt_r <= rx_cnt_r + 6'h01;
        rx_chk_r <= {rx_chk_r[5:0], cmd_in};
      end
      else
      begin
        rx_busy_r <= 1'b0; // End bit consumed
        rx_done_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Card state and status flags
  mcg_cmd_t    cmd;
  logic        crc_ok;
  mcg_state_t  st_r;
  logic        crc_err_r;
  logic        illegal_r;
  logic        rsp_go_r;
  logic        rd_go_r;
  logic [31:0] rd_addr_r;
  logic        status_read;
  logic        rd_done;
  logic        go_idle;
  assign cmd    = mcg_cmd_t'(rx_sh_r[37:0]);
  assign go_idle = rx_done_r && crc_ok && cmd.index == `MCG_IDX_GO_IDLE; // RULE9
  assign crc_ok = rx_chk_r == rx_crc_r; // RULE2
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r      <= ST_IDLE;
      rsp_go_r  <= 1'b0;
      rd_go_r   <= 1'b0;
      rd_addr_r <= 32'h0000_0000;
    end
    else
    begin
      rsp_go_r <= 1'b0;
      rd_go_r  <= 1'b0;
      if (por_r)
        st_r <= ST_IDLE; // RULE8
      else if (rx_done_r && !crc_ok)
        rsp_go_r <= 1'b1; // RULE4
      else if (rx_done_r)
      begin
        unique case (1'b1)
          cmd.index == `MCG_IDX_GO_IDLE:
            st_r <= ST_IDLE; // RULE9
          st_r == ST_IDLE && cmd.index == `MCG_IDX_OP_COND:
          begin
            st_r     <= ST_READY;
            rsp_go_r <= 1'b1;
          end
          st_r == ST_READY && cmd.index == `MCG_IDX_ALL_CID:
          begin
            st_r     <= ST_IDENT;
            rsp_go_r <= 1'b1;
          end
          st_r == ST_IDENT && cmd.index == `MCG_IDX_SET_ADDR:
          begin
            st_r     <= ST_STBY;
            rsp_go_r <= 1'b1;
          end
          st_r == ST_STBY && cmd.index != `MCG_IDX_GO_IDLE:
          begin
            rsp_go_r <= 1'b1;
            if (cmd.index == `MCG_IDX_READ && vdd_ok) // RULE10 RULE15
            begin
              st_r      <= ST_DATA;
              rd_go_r   <= 1'b1;
              rd_addr_r <= cmd.arg;
            end
          end
          default:
            ; // RULE14
        endcase
      end
      else if (st_r == ST_DATA && rd_done)
        st_r <= ST_STBY;
    end
  end
  // Set wins over clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      crc_err_r <= 1'b0;
    else if (rx_done_r && !crc_ok)
      crc_err_r <= 1'b1; // RULE16
    else if (status_read || go_idle)
      crc_err_r <= 1'b0; // RULE17
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      illegal_r <= 1'b0;
    else if (rx_done_r && crc_ok && st_r == ST_STBY && cmd.index != `MCG_IDX_READ &&
             cmd.index != `MCG_IDX_GO_IDLE)
      illegal_r <= 1'b1;
    else if (status_read || go_idle)
      illegal_r <= 1'b0; // RULE17
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      status <= '0;
    else
      status <= '{crc_err: crc_err_r, illegal: illegal_r, state: st_r};
  end

  ////////////////////////////////////////////////////////////////////////
  // Response transmitter: start, dir, index, status, crc7, end
  logic [47:0] tx_sh_r;
  logic [5:0]  tx_cnt_r;
  logic [6:0]  tx_crc_r;
  assign status_read = rsp_go_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= '0;
      tx_cnt_r  <= 6'h00;
      tx_crc_r  <= 7'h00;
      cmd_out   <= 1'b1;
      cmd_oe    <= 1'b0;
    end
    else if (rsp_go_r)
    begin
      tx_busy_r <= 1'b1;
      tx_cnt_r  <= 6'h00;
      tx_crc_r  <= 7'h00; // RULE18
      tx_sh_r   <= {2'b00, cmd.index, 22'h0, crc_err_r | (rx_done_r && !crc_ok), illegal_r,
                    5'(st_r), 3'h0, 8'h01};
    end
    else if (tx_busy_r)
    begin
      cmd_oe   <= 1'b1;
      tx_cnt_r <= tx_cnt_r + 6'h01;
      tx_sh_r  <= {tx_sh_r[46:0], 1'b1};
      if (tx_cnt_r < `MCG_CMD_BITS)
      begin
        cmd_out  <= tx_sh_r[47];
        tx_crc_r <= crc7_step(tx_crc_r, tx_sh_r[47]); // RULE3
      end
      else if (tx_cnt_r < `MCG_CMD_BITS + 6'd7)
      begin
        cmd_out  <= tx_crc_r[6];
        tx_crc_r <= {tx_crc_r[5:0], 1'b0};
      end
      else if (tx_cnt_r == `MCG_CMD_BITS + 6'd7)
        cmd_out <= 1'b1;
      else
      begin
        tx_busy_r <= 1'b0;
        cmd_oe    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data: memory bytes through the FIFO, then serialised
  logic [11:0] fetch_left_r;
  logic        fifo_ready;
  logic        f_valid;
  logic [7:0]  f_data;
  logic        f_take;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_left_r <= 12'h000;
      mem_addr     <= 32'h0000_0000;
      mem_req      <= 1'b0;
    end
    else if (rd_go_r)
    begin
      fetch_left_r <= (blk_len == 12'h000 || blk_len > `MCG_MAX_BLK) ? `MCG_MAX_BLK : blk_len; // RULE6
      mem_addr     <= rd_addr_r;
      mem_req      <= 1'b1;
    end
    else if (mem_req && mem_valid && fifo_ready)
    begin
      fetch_left_r <= fetch_left_r - 12'h001;
      mem_addr     <= mem_addr + 32'h0000_0001;
      mem_req      <= fetch_left_r != 12'h001;
    end
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mem_ready <= 1'b0;
    else
      mem_ready <= 1'b0;
  end
  mcg_fifo #(.WIDTH(8), .DEPTH(`MCG_FIFO_DEPTH)) u_fifo
  (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (mem_req && mem_valid),
    .in_ready  (fifo_ready),
    .in_data   (mem_data),
    .out_valid (f_valid),
    .out_ready (f_take),
    .out_data  (f_data)
  );

  typedef enum logic [2:0] {DX_IDLE, DX_START, DX_PAY, DX_CRC, DX_END} mcg_dx_t;
  mcg_dx_t     dx_r;
  logic [11:0] dx_left_r;
  logic [7:0]  dx_byte_r;
  logic [3:0]  dx_bit_r;
  logic [15:0] dcrc_r;
  // Hold the first byte until the response has left the line, or it is lost
  assign f_take  = ((dx_r == DX_START && !tx_busy_r) ||
                    (dx_r == DX_PAY && dx_bit_r == 4'h0 && dx_left_r != 12'h000)) && f_valid;
  assign rd_done = dx_r == DX_END;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dx_r      <= DX_IDLE;
      dx_left_r <= 12'h000;
      dx_byte_r <= 8'h00;
      dx_bit_r  <= 4'h0;
      dcrc_r    <= 16'h0000;
      dat_out   <= 1'b1;
      dat_oe    <= 1'b0;
    end
    else
    begin
      unique case (dx_r)
        DX_IDLE:
          begin
            dat_oe <= 1'b0;
            if (rd_go_r)
            begin
              dx_r      <= DX_START;
              dx_left_r <= (blk_len == 12'h000 || blk_len > `MCG_MAX_BLK) ? `MCG_MAX_BLK : blk_len;
            end
          end
        DX_START:
          if (f_valid && !tx_busy_r)
          begin
            dat_oe    <= 1'b1;
            dat_out   <= 1'b0;
            dcrc_r    <= 16'h0000; // RULE18
            dx_byte_r <= f_data;
            dx_bit_r  <= 4'h8;
            dx_left_r <= dx_left_r - 12'h001;
            dx_r      <= DX_PAY;
          end
        DX_PAY:
          if (dx_bit_r != 4'h0)
          begin
            dat_out   <= dx_byte_r[7];
            dcrc_r    <= crc16_step(dcrc_r, dx_byte_r[7]); // RULE5
            dx_byte_r <= {dx_byte_r[6:0], 1'b0};
            dx_bit_r  <= dx_bit_r - 4'h1;
          end
          else if (dx_left_r == 12'h000)
          begin
            dat_out  <= dcrc_r[15]; // RULE19
            dcrc_r   <= {dcrc_r[14:0], 1'b0};
            dx_bit_r <= 4'hF;
            dx_r     <= DX_CRC;
          end
          else if (f_valid)
          begin
            dat_out   <= f_data[7];
            dcrc_r    <= crc16_step(dcrc_r, f_data[7]);
            dx_byte_r <= {f_data[6:0], 1'b0};
            dx_bit_r  <= 4'h7;
            dx_left_r <= dx_left_r - 12'h001;
          end
        DX_CRC:
          begin
            dat_out <= dcrc_r[15];
            dcrc_r  <= {dcrc_r[14:0], 1'b0};
            if (dx_bit_r == 4'h1)
              dx_r <= DX_END;
            dx_bit_r <= dx_bit_r - 4'h1;
          end
        DX_END:
          begin
            // End bit still driven; the enable drops in idle
            dat_out <= 1'b1; // RULE19
            dx_r    <= DX_IDLE;
          end
        default:
          dx_r <= DX_IDLE;
      endcase
    end
  end
endmodule : mcg_card

/* verilog/mcg_cfg.svh */
`ifndef MCG_CFG_SVH
`define MCG_CFG_SVH
`define MCG_CMD_BITS     6'd40
`define MCG_CMD_LAST     6'd39
`define MCG_CRC7_POLY    7'h09
`define MCG_CRC16_POLY   16'h1021
`define MCG_RSP_BITS     6'd48
`define MCG_IDX_GO_IDLE  6'h00
`define MCG_IDX_OP_COND  6'h01
`define MCG_IDX_ALL_CID  6'h02
`define MCG_IDX_SET_ADDR 6'h03
`define MCG_IDX_READ     6'h11
`define MCG_MAX_BLK      12'h800
`define MCG_FIFO_DEPTH   32
`define MCG_POR_CYCLES   4'h8
`endif

/* verilog/mcg_fifo.sv */
`timescale 1ns/100ps
module mcg_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 32)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             wr;
  logic             rd;
  assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data  = mem[rp_r[AW-1:0]];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wp_r <= '0;
    else if (wr)
      wp_r <= wp_r + 1'b1;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rp_r <= '0;
    else if (rd)
      rp_r <= rp_r + 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (wr)
      mem[wp_r[AW-1:0]] <= in_data;
  end
endmodule : mcg_fifo

/* verilog/mcg_pkg.sv */
package mcg_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_READY, ST_IDENT, ST_STBY, ST_DATA} mcg_state_t;
  typedef struct packed
  {
    logic [5:0]  index;
    logic [31:0] arg;
  } mcg_cmd_t;
  typedef struct packed
  {
    logic       crc_err;
    logic       illegal;
    logic [2:0] state;
  } mcg_status_t;
endpackage : mcg_pkg
